// [logic/mom_params.svh]
// Constants for the memory overlay map decoder
`ifndef MOM_PARAMS_SVH
`define MOM_PARAMS_SVH
`define MOM_OFF_CTRL      12'h000
`define MOM_OFF_STATUS    12'h004
`define MOM_OFF_REQ       12'h008
`define MOM_OFF_RESULT    12'h00c
`define MOM_OFF_BYTEADDR  12'h010
`define MOM_CTRL_RST      32'h0000_0000
`define MOM_PM_SPLIT      14'h2000
`define MOM_DM_REG_BASE   14'h3fe0
`define MOM_OVL_INT       2'd0
`define MOM_OVL_ONE       2'd1
`define MOM_OVL_TWO       2'd2
`define MOM_BOOT_WORDS    6'd32
`define MOM_STACK_EMPTY   4'h0
`endif

// [logic/mom_pkg.sv]
// Types for the memory overlay map decoder
package mom_pkg;
  typedef enum logic [1:0] {
    MOM_SP_PM = 2'h0,
    MOM_SP_DM = 2'h1,
    MOM_SP_IO = 2'h2,
    MOM_SP_BM = 2'h3
  } mom_space_t;
  typedef enum logic [1:0] {
    MOM_TG_INT  = 2'h0,
    MOM_TG_EXT  = 2'h1,
    MOM_TG_CREG = 2'h2,
    MOM_TG_ERR  = 2'h3
  } mom_target_t;
  typedef struct packed {
    mom_space_t  space;
    logic [13:0] addr;
    logic [7:0]  page;
  } mom_req_t;
  typedef struct packed {
    mom_target_t target;
    logic [13:0] ext_addr;
    logic [21:0] byte_addr;
    logic [2:0]  waits;
  } mom_res_t;
endpackage

// [logic/mom_decode.sv]
// Combinational address decoder for all four memory spaces
`timescale 1ns/1ps
`default_nettype none
`include "mom_params.svh"
module mom_decode
  import mom_pkg::*;
(
  input  wire mom_req_t   req,
  input  wire logic       map_hi,
  input  wire logic [1:0] pm_ovl,
  input  wire logic [1:0] dm_ovl,
  input  wire logic [2:0] data_wait_count,
  input  wire logic [11:0] io_waits,
  output mom_res_t        res
);
  // Overlay value 0, 1 or 2 is legal; anything else is refused
  function automatic mom_target_t ovl_tgt(input logic [1:0] o);
    mom_target_t t;
    t = MOM_TG_ERR;
    if (o == `MOM_OVL_INT) begin
      t = MOM_TG_INT;
    end else if (o == `MOM_OVL_ONE || o == `MOM_OVL_TWO) begin
      t = MOM_TG_EXT;
    end
    return t;
  endfunction

  always_comb begin
    res.target    = MOM_TG_INT;
    res.ext_addr  = 14'h0000;
    res.byte_addr = {req.page, req.addr};
    res.waits     = 3'h0;
    case (req.space)
      MOM_SP_PM: begin
        if (map_hi) begin
          // Low half external, upper half internal, no overlays
          res.target   = (req.addr < `MOM_PM_SPLIT) ? MOM_TG_EXT : MOM_TG_INT;
          res.ext_addr = req.addr;
        end else if (req.addr >= `MOM_PM_SPLIT) begin
          res.target   = ovl_tgt(pm_ovl);
          res.ext_addr = {pm_ovl == `MOM_OVL_TWO, req.addr[12:0]};
        end
      end
      MOM_SP_DM: begin
        if (req.addr >= `MOM_DM_REG_BASE) begin
          res.target = MOM_TG_CREG;
        end else if (req.addr < `MOM_PM_SPLIT) begin
          res.target   = ovl_tgt(dm_ovl);
          res.ext_addr = {dm_ovl == `MOM_OVL_TWO, req.addr[12:0]};
        end
        if (res.target == MOM_TG_EXT) begin
          res.waits = data_wait_count;
        end
      end
      MOM_SP_IO: begin
        // Upper three bits left at zero; peripherals must not rely on them
        res.target   = MOM_TG_EXT;
        res.ext_addr = {3'h0, req.addr[10:0]};
        res.waits    = io_waits[3*req.addr[10:9] +: 3];
      end
      MOM_SP_BM: begin
        res.target = MOM_TG_EXT;
      end
      default: begin
        res.target = MOM_TG_ERR;
      end
    endcase
  end
endmodule
`default_nettype wire

// [logic/mom_boot.sv]
// Post-reset boot sequencer: holds the core until boot words are loaded
`timescale 1ns/1ps
`default_nettype none
`include "mom_params.svh"
module mom_boot
  import mom_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic map_hi,
  input  wire logic bus_req,
  input  wire logic word_loaded,
  output logic      booting,
  output logic      run
);
  typedef enum logic [2:0] {
    MOM_BS_DECIDE = 3'b001,
    MOM_BS_LOAD   = 3'b010,
    MOM_BS_RUN    = 3'b100
  } mom_bstate_t;
  mom_bstate_t st_q;
  logic [5:0]  cnt_q;

  // Boot decision taken at the first clean cycle after release
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= MOM_BS_DECIDE;
    end else begin
      case (st_q)
        MOM_BS_DECIDE: begin
          if (!map_hi && !bus_req) begin
            st_q <= MOM_BS_LOAD;
          end else begin
            st_q <= MOM_BS_RUN;
          end
        end
        MOM_BS_LOAD: begin
          if (word_loaded && cnt_q == `MOM_BOOT_WORDS - 6'd1) begin
            st_q <= MOM_BS_RUN;
          end
        end
        MOM_BS_RUN: st_q <= MOM_BS_RUN;
        default: st_q <= MOM_BS_DECIDE;
      endcase
    end
  end

  // Loaded-word counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= 6'h00;
    end else if (st_q == MOM_BS_LOAD && word_loaded) begin
      cnt_q <= cnt_q + 6'd1;
    end
  end

  assign booting = (st_q == MOM_BS_LOAD);
  assign run     = (st_q == MOM_BS_RUN);

  a_boot_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    booting |-> !run) else $error("run during boot");
  a_boot_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (booting && word_loaded && cnt_q == 6'd31) |=> run) else $error("boot did not end");
endmodule
`default_nettype wire

// [logic/mom_top.sv]
// Memory overlay map decoder with AXI4-Lite registers
// What this block does
// - Master reset empties stack pointers, masks interrupts, clears mode status.
// - Boot runs after reset when no bus request and map pin low.
// - After boot, first fetch is from program address 0x0000.
// - Later resets keep the clock running, no stabilisation wait.
// - Program RAM is 16K x 24 with two accesses per cycle.
// - Map low: program low half internal; upper half follows program overlay.
// - Program overlay drives bit 13 low for 1, high for 2.
// - Overlay selects are not stacked; sequencer ignores program overlay.
// - Map high: no boot, no program overlay; program low half external.
// - Data 0x3FE0-0x3FFF are control registers; 0x2000-0x3FDF internal RAM.
// - Data low half internal for overlay zero, external for one or two; overlay three is refused.
// - Data overlay drives bit 13 low for 1, high for 2.
// - Internal accesses take one cycle; external data uses data wait count.
// - I/O uses eleven address bits over 2048 sixteen-bit locations.
// - I/O waits 0-7 from one of four settings by address bits 10:9.
// - Byte memory forms 22-bit address from page and address.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mom_params.svh"
module mom_top
  import mom_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        memory_map_select_pin,
  input  wire logic        bus_req_pin,
  input  wire logic        boot_word_loaded,
  input  wire logic [13:0] pm_fetch_addr,
  input  wire logic [13:0] pm_data_addr,
  input  wire logic        pm_data_en,
  output logic             pm_fetch_ok,
  output logic             pm_data_ok,
  output logic             core_run,
  output logic             core_booting,
  output logic [15:0]      mode_status_register,
  output logic [3:0]       stack_ptr,
  output logic [15:0]      int_mask,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; not reset, so the pins are settled when reset lifts
  logic [1:0] map_s_q;
  logic [1:0] breq_s_q;
  logic       map_hi;
  always_ff @(posedge clk_sys) begin
    map_s_q  <= {map_s_q[0], memory_map_select_pin};
    breq_s_q <= {breq_s_q[0], bus_req_pin};
  end
  assign map_hi = map_s_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Control state
  // ctrl: [1:0] program overlay, [3:2] data overlay, [6:4] data waits,
  // [18:7] four I/O region waits
  logic [31:0] ctrl_q;
  logic [1:0]  pm_ovl;
  logic [1:0]  dm_ovl;
  logic [15:0] req_q;
  logic [7:0]  page_q;
  logic        cfg_err_q;
  logic        clr_err;
  mom_req_t    dreq;
  mom_res_t    dres;
  mom_res_t    res_q;

  // Map-high mode forces program overlay to zero
  assign pm_ovl = map_hi ? `MOM_OVL_INT : ctrl_q[1:0];
  assign dm_ovl = ctrl_q[3:2];

  // Master reset effects; these registers are never pushed on any stack
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_status_register <= 16'h0000;
      stack_ptr            <= `MOM_STACK_EMPTY;
      int_mask             <= 16'h0000;
    end else begin
      mode_status_register <= {15'h0000, core_run};
      stack_ptr            <= stack_ptr;
      int_mask             <= int_mask;
    end
  end
  // reset is synchronous, so the clock keeps running through it

  ////////////////////////////////////////////////////////////////////////
  // Program RAM dual access: fetch and data read in one cycle
  // both ports are checked against the map each cycle, 16K x 24 space
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pm_fetch_ok <= 1'b0;
      pm_data_ok  <= 1'b0;
    end else begin
      pm_fetch_ok <= core_run && (map_hi ? pm_fetch_addr >= `MOM_PM_SPLIT
                     : (pm_fetch_addr < `MOM_PM_SPLIT || pm_ovl == `MOM_OVL_INT));
      pm_data_ok  <= pm_data_en && (map_hi ? pm_data_addr >= `MOM_PM_SPLIT
                     : (pm_data_addr < `MOM_PM_SPLIT || pm_ovl == `MOM_OVL_INT));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot sequencer and decoder
  mom_boot u_boot (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .map_hi      (map_hi),
    .bus_req     (breq_s_q[1]),
    .word_loaded (boot_word_loaded),
    .booting     (core_booting),
    .run         (core_run)
  );

  assign dreq.space = mom_space_t'(req_q[15:14]);
  assign dreq.addr  = req_q[13:0];
  assign dreq.page  = page_q;

  mom_decode u_dec (
    .req      (dreq),
    .map_hi   (map_hi),
    .pm_ovl   (pm_ovl),
    .dm_ovl   (dm_ovl),
    .data_wait_count    (ctrl_q[6:4]),
    .io_waits (ctrl_q[18:7]),
    .res      (dres)
  );

  // Registered decode result; bad overlay value latches an error flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      res_q     <= '0;
      cfg_err_q <= 1'b0;
    end else begin
      res_q <= dres;
      if (dres.target == MOM_TG_ERR) begin
        cfg_err_q <= 1'b1;
      end else if (clr_err) begin
        cfg_err_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read at a time
  logic        aw_q;
  logic        w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_wr;
  logic [31:0] rd_mux;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr         = aw_q && w_q && !s_axi_bvalid;
  assign clr_err       = do_wr && awaddr_q == `MOM_OFF_STATUS && wdata_q[0] && wstrb_q[0];

  // Capture address and data in either order
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_q <= 1'b0;
      end
    end
  end

  // Register writes with byte strobes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= `MOM_CTRL_RST;
      req_q  <= 16'h0000;
      page_q <= 8'h00;
    end else if (do_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_q[i] && awaddr_q == `MOM_OFF_CTRL) begin
          ctrl_q[8*i +: 8] <= wdata_q[8*i +: 8];
        end
      end
      if (awaddr_q == `MOM_OFF_REQ) begin
        if (wstrb_q[0]) req_q[7:0]  <= wdata_q[7:0];
        if (wstrb_q[1]) req_q[15:8] <= wdata_q[15:8];
        if (wstrb_q[2]) page_q      <= wdata_q[23:16];
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == `MOM_OFF_CTRL || awaddr_q == `MOM_OFF_STATUS
                       || awaddr_q == `MOM_OFF_REQ) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    case (s_axi_araddr)
      `MOM_OFF_CTRL:     rd_mux = {13'h0000, ctrl_q[18:2], pm_ovl};
      `MOM_OFF_STATUS:   rd_mux = {28'h0000000, map_hi, core_booting, core_run, cfg_err_q};
      `MOM_OFF_REQ:      rd_mux = {8'h00, page_q, req_q};
      `MOM_OFF_RESULT:   rd_mux = {11'h000, res_q.waits, res_q.target, 2'b00, res_q.ext_addr};
      `MOM_OFF_BYTEADDR: rd_mux = {10'h000, res_q.byte_addr};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (s_axi_araddr <= `MOM_OFF_BYTEADDR && s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_rst_clear: assert property (@(posedge clk_sys)
    sys_rst |=> mode_status_register == 16'h0000 && stack_ptr == 4'h0 && int_mask == 16'h0000)
    else $error("reset did not clear state");
  a_pm_ovl_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dreq.space == MOM_SP_PM && !map_hi && dreq.addr >= 14'h2000 && pm_ovl == 2'd2)
    |-> dres.target == MOM_TG_EXT && dres.ext_addr == {1'b1, dreq.addr[12:0]})
    else $error("program overlay 2 address wrong");
  a_pm_map_hi: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dreq.space == MOM_SP_PM && map_hi) |-> (dres.target == MOM_TG_EXT) == (dreq.addr < 14'h2000))
    else $error("map-high program decode wrong");
  a_dm_creg: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dreq.space == MOM_SP_DM && dreq.addr >= 14'h3fe0) |-> dres.target == MOM_TG_CREG)
    else $error("control register window wrong");
  a_dm_ovl_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dreq.space == MOM_SP_DM && dreq.addr < 14'h2000 && dm_ovl == 2'd1)
    |-> dres.ext_addr[13] == 1'b0 && dres.waits == ctrl_q[6:4])
    else $error("data overlay 1 wrong");
  a_io_region: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dreq.space == MOM_SP_IO && dreq.addr[10:9] == 2'd3) |-> dres.waits == ctrl_q[18:16]
    && dres.ext_addr[13:11] == 3'h0) else $error("I/O region 3 waits wrong");
  a_ovl_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (dreq.space == MOM_SP_DM && dreq.addr < 14'h2000 && dm_ovl == 2'd3)
    |=> cfg_err_q) else $error("bad overlay not flagged");
  a_byte_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dres.byte_addr == {page_q, req_q[13:0]}) else $error("byte address wrong");
endmodule
`default_nettype wire

// [tb/mom_boot_mem.sv]
// Byte-wide boot memory model that answers the boot loader
`timescale 1ns/1ps
`default_nettype none
module mom_boot_mem (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       core_booting,
  input  wire logic [3:0] gap,
  output logic            boot_word_loaded,
  output logic [7:0]      words
);
  logic [3:0] wait_q;
  ////////////////////////////////////////////////////////////
  // One word per gap+1 cycles, or per 2 cycles when gap is 0, only while the loader asks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wait_q           <= 4'h0;
      boot_word_loaded <= 1'b0;
      words            <= 8'h00;
    end else if (core_booting && !boot_word_loaded && wait_q == gap) begin
      boot_word_loaded <= 1'b1;
      words            <= words + 8'h01;
      wait_q           <= 4'h0;
    end else begin
      // Never back to back: a real byte fetch takes several reads
      boot_word_loaded <= 1'b0;
      if (core_booting && wait_q != gap) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/memory_overlay_map_decoder_tb.sv]
// Self-checking bench for the memory overlay map decoder
`timescale 1ns/1ps
`default_nettype none
`include "mom_params.svh"
module memory_overlay_map_decoder_tb
  import mom_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] req;
    logic [31:0] mask;
    logic [31:0] exp;
  } mom_row_t;
  logic        clk_sys, sys_rst, memory_map_select_pin, bus_req_pin, boot_word_loaded;
  logic        pm_data_en, pm_fetch_ok, pm_data_ok, core_run, core_booting;
  logic [13:0] pm_fetch_addr, pm_data_addr;
  logic [15:0] mode_status_register, int_mask;
  logic [3:0]  stack_ptr, s_axi_wstrb, gap;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  words;
  int          err_count, samples_checked, cyc;
  mom_row_t    rows [16];
  localparam logic [31:0] MT = 32'h0003_0000;
  localparam logic [31:0] MW = 32'h001f_0000;
  localparam logic [31:0] MTE = 32'h0003_3fff;
  localparam logic [31:0] MA = 32'h001f_3fff;

  mom_top dut (.clk_sys, .sys_rst, .memory_map_select_pin, .bus_req_pin, .boot_word_loaded, .pm_fetch_addr,
    .pm_data_addr, .pm_data_en, .pm_fetch_ok, .pm_data_ok, .core_run, .core_booting, .mode_status_register,
    .stack_ptr, .int_mask, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  mom_boot_mem boot_mem (.clk_sys, .sys_rst, .core_booting, .gap, .boot_word_loaded, .words);

  ////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////
  // Helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask

  function automatic logic [31:0] rq(input mom_space_t s, input logic [13:0] a);
    return {16'h0, s, a};
  endfunction

  function automatic logic [31:0] res(input logic [2:0] w, input mom_target_t t, input logic [13:0] e);
    return {11'h0, w, t, 2'h0, e};
  endfunction

  // Handshakes sampled at the rising edge, before that edge's updates land
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic tb;
    tb = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!tb) begin
      @(posedge clk_sys);
      tb = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [11:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!tr) begin
      @(posedge clk_sys);
      ta  = s_axi_arvalid & s_axi_arready;
      tr  = s_axi_rvalid;
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask

  // Pins held well past the two-flop synchroniser before release
  task automatic do_reset(input logic map, input logic breq);
    @(posedge clk_sys);
    memory_map_select_pin <= map;
    bus_req_pin           <= breq;
    sys_rst               <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("stack_ptr", {28'h0, stack_ptr}, 32'h0);
    chk("int_mask", {16'h0, int_mask}, 32'h0);
    chk("mode_status", {16'h0, mode_status_register}, 32'h0);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic dec(input logic [31:0] req, input logic [31:0] mask, input logic [31:0] exp);
    axi_wr(`MOM_OFF_REQ, req);
    axi_rd(`MOM_OFF_RESULT);
    chk("result", rd & mask, exp & mask);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {memory_map_select_pin, bus_req_pin, pm_data_en, pm_fetch_addr, pm_data_addr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    sys_rst = 1'b1;
    gap = 4'h3;
    rows[0]  = '{32'h0, rq(MOM_SP_PM, 14'h2345), MT, res(3'h0, MOM_TG_INT, 14'h0)};
    rows[1]  = '{32'h1, rq(MOM_SP_PM, 14'h2345), MTE, res(3'h0, MOM_TG_EXT, 14'h0345)};
    rows[2]  = '{32'h2, rq(MOM_SP_PM, 14'h2345), MTE, res(3'h0, MOM_TG_EXT, 14'h2345)};
    rows[3]  = '{32'h2, rq(MOM_SP_PM, 14'h1abc), MT, res(3'h0, MOM_TG_INT, 14'h0)};
    rows[4]  = '{32'h3, rq(MOM_SP_PM, 14'h2345), MT, res(3'h0, MOM_TG_ERR, 14'h0)};
    rows[5]  = '{32'h54, rq(MOM_SP_DM, 14'h1234), MA, res(3'h5, MOM_TG_EXT, 14'h1234)};
    rows[6]  = '{32'h38, rq(MOM_SP_DM, 14'h0010), MA, res(3'h3, MOM_TG_EXT, 14'h2010)};
    rows[7]  = '{32'h70, rq(MOM_SP_DM, 14'h0010), MW, res(3'h0, MOM_TG_INT, 14'h0)};
    rows[8]  = '{32'h38, rq(MOM_SP_DM, 14'h3fdf), MT, res(3'h0, MOM_TG_INT, 14'h0)};
    rows[9]  = '{32'h38, rq(MOM_SP_DM, 14'h3fe0), MT, res(3'h0, MOM_TG_CREG, 14'h0)};
    rows[10] = '{32'h38, rq(MOM_SP_DM, 14'h3fff), MT, res(3'h0, MOM_TG_CREG, 14'h0)};
    rows[11] = '{32'h0c, rq(MOM_SP_DM, 14'h0010), MT, res(3'h0, MOM_TG_ERR, 14'h0)};
    rows[12] = '{32'h7ac80, rq(MOM_SP_IO, 14'h01ff), MA, res(3'h1, MOM_TG_EXT, 14'h01ff)};
    rows[13] = '{32'h7ac80, rq(MOM_SP_IO, 14'h0200), MA, res(3'h3, MOM_TG_EXT, 14'h0200)};
    rows[14] = '{32'h7ac80, rq(MOM_SP_IO, 14'h05ff), MA, res(3'h5, MOM_TG_EXT, 14'h05ff)};
    rows[15] = '{32'h7ac80, rq(MOM_SP_IO, 14'h3e00), MA, res(3'h7, MOM_TG_EXT, 14'h0600)};
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("stack_ptr", {28'h0, stack_ptr}, 32'h0);
    chk("int_mask", {16'h0, int_mask}, 32'h0);
    chk("mode_status", {16'h0, mode_status_register}, 32'h0);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("booting", {31'h0, core_booting}, 32'h1);
    chk("run", {31'h0, core_run}, 32'h0);
    chk("fetch_ok", {31'h0, pm_fetch_ok}, 32'h0);
    while (core_run !== 1'b1) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("boot_words", {24'h0, words}, 32'd32);
    chk("fetch_ok", {31'h0, pm_fetch_ok}, 32'h1);
    $display("test boot done");
    // Decode table, every overlay value and I/O region
    for (int i = 0; i < 16; i++) begin
      axi_wr(`MOM_OFF_CTRL, rows[i].ctrl);
      dec(rows[i].req, rows[i].mask, rows[i].exp);
    end
    $display("test decode table done");
    axi_wr(`MOM_OFF_REQ, {8'h0, 8'ha5, MOM_SP_BM, 14'h1234});
    axi_rd(`MOM_OFF_BYTEADDR);
    chk("byte_addr", rd, {10'h0, 8'ha5, 14'h1234});
    axi_rd(12'h020);
    chk("unmapped_resp", {30'h0, rsp}, 32'h2);
    chk("unmapped_data", rd, 32'h0);
    $display("test byte and unmapped done");
    // Fetch and data port in the same cycle, one-cycle answer
    axi_wr(`MOM_OFF_CTRL, 32'h1);
    pm_fetch_addr <= 14'h0100;
    pm_data_addr  <= 14'h2345;
    pm_data_en    <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("fetch_ok", {31'h0, pm_fetch_ok}, 32'h1);
    chk("data_ok", {31'h0, pm_data_ok}, 32'h0);
    @(posedge clk_sys);
    pm_data_addr <= 14'h1fff;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("data_ok", {31'h0, pm_data_ok}, 32'h1);
    $display("test program ports done");
    // Compatibility map after a mid-run reset: no boot, no program overlay
    gap <= 4'h0;
    do_reset(1'b1, 1'b0);
    chk("run", {31'h0, core_run}, 32'h1);
    chk("booting", {31'h0, core_booting}, 32'h0);
    axi_wr(`MOM_OFF_CTRL, 32'h1);
    dec(rq(MOM_SP_PM, 14'h1000), MT, res(3'h0, MOM_TG_EXT, 14'h0));
    dec(rq(MOM_SP_PM, 14'h2345), MT, res(3'h0, MOM_TG_INT, 14'h0));
    axi_rd(`MOM_OFF_CTRL);
    chk("ctrl_pm_ovl", {30'h0, rd[1:0]}, 32'h0);
    $display("test map high done");
    // Pending bus request at release skips the boot load
    do_reset(1'b0, 1'b1);
    chk("run", {31'h0, core_run}, 32'h1);
    chk("booting", {31'h0, core_booting}, 32'h0);
    $display("test bus request done");
    complete_run();
  end
endmodule
`default_nettype wire
